// ===== src/gpp_regs.svh
`ifndef GPP_REGS_SVH
`define GPP_REGS_SVH

`define GPP_OFS_A_DATA 6'h00
`define GPP_OFS_A_DIR 6'h04
`define GPP_OFS_A_PULLUP 6'h08
`define GPP_OFS_A_ANALOG 6'h0c
`define GPP_OFS_B_DATA 6'h10
`define GPP_OFS_B_DIR 6'h14
`define GPP_OFS_B_PULLUP 6'h18
`define GPP_OFS_B_ANALOG 6'h1c
`define GPP_OFS_STEER 6'h20
`define GPP_OFS_OPTION 6'h24

`define GPP_INPUT_ONLY_BIT 5
`define GPP_GLOBAL_PU_BIT 7
`define GPP_STEER_CLK_BIT 0
`define GPP_A_PU_MASK 8'h2f
`define GPP_A_AN_MASK 8'h0f
`define GPP_B_IMPL_MASK 8'hf7
`define GPP_B_AN_MASK 8'h36
`define GPP_RST_DIR 8'hff
`define GPP_RST_A_PULLUP 8'h2f
`define GPP_RST_A_ANALOG 8'h0f
`define GPP_RST_B_PULLUP 8'h00
`define GPP_RST_B_ANALOG 8'h36
`define GPP_RST_STEER 8'h00
`define GPP_RST_OPTION 8'hff
`define GPP_RST_LATCH 8'h00
`endif

// ===== src/gpp_pkg.sv
package gpp_pkg;
	typedef enum logic [1:0] {
		GPP_IDLE = 2'b00,
		GPP_ANSWER = 2'b01
	} gpp_bus_state_t;
endpackage

// ===== src/gpp_pin_sync.sv
module gpp_pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			level_o <= '0;
		end else begin
			meta_r <= pin_i;
			s2_r <= meta_r;
			s3_r <= s2_r;
			// Accept a bit once two stages agree
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_r[i] == s3_r[i]) begin
					level_o[i] <= s3_r[i];
				end
			end
		end
	end
endmodule

// ===== src/gpp_port.sv
`include "gpp_regs.svh"

module gpp_port (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic external_reset_pin_mode_i,
	input wire logic [7:0] port_a_pin_i,
	output logic [7:0] port_a_pin_o,
	output logic [7:0] port_a_pin_oe_o,
	output logic [7:0] port_a_pullup_o,
	output logic [7:0] port_a_digital_in_en_o,
	input wire logic [7:0] port_b_pin_i,
	output logic [7:0] port_b_pin_o,
	output logic [7:0] port_b_pin_oe_o,
	output logic [7:0] port_b_pullup_o,
	output logic [7:0] port_b_digital_in_en_o,
	input wire logic [7:0] periph_b_en_i,
	input wire logic [7:0] periph_b_out_i,
	input wire logic sync_clock_en_i,
	input wire logic sync_clock_out_i,
	output logic sync_clock_pin_choice_o
);
	gpp_pkg::gpp_bus_state_t state_r;
	logic [7:0] a_latch_r;
	logic [7:0] port_a_direction_r;
	logic [7:0] port_a_pullup_enable_r;
	logic [7:0] port_a_analog_select_r;
	logic [7:0] b_latch_r;
	logic [7:0] port_b_direction_r;
	logic [7:0] port_b_pullup_enable_r;
	logic [7:0] port_b_analog_select_r;
	logic [7:0] pin_function_steering_r;
	logic [7:0] option_control_r;
	logic [7:0] a_level;
	logic [7:0] b_level;
	logic [7:0] a_read;
	logic [7:0] b_read;
	logic [7:0] a_dir_eff;
	logic [7:0] a_pu_nxt;
	logic [7:0] b_pu_nxt;
	logic [7:0] b_own_en;
	logic [7:0] b_own_out;
	logic [7:0] a_own_en;
	logic [7:0] a_own_out;
	logic [7:0] rdata_nxt;
	logic [7:0] wbyte;
	logic wr_go;
	logic global_pu_on;

	gpp_pin_sync #(
		.WIDTH(8)
	) u_sync_a (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.pin_i(port_a_pin_i),
		.level_o(a_level)
	);

	gpp_pin_sync #(
		.WIDTH(8)
	) u_sync_b (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.pin_i(port_b_pin_i),
		.level_o(b_level)
	);

	assign wbyte = avs_byteenable_i[0] ? avs_writedata_i[7:0] : 8'h00;
	// Write lands at the edge where the master sees waitrequest low
	assign wr_go = (state_r == gpp_pkg::GPP_ANSWER) && avs_write_i && avs_byteenable_i[0];

	// Input-only pin always an input
	assign a_dir_eff = port_a_direction_r | (8'h01 << `GPP_INPUT_ONLY_BIT);
	// Pull-up control bit is active low in the option register
	assign global_pu_on = !option_control_r[`GPP_GLOBAL_PU_BIT];

	// Analog pins and port B bit 3 read zero; others show synchronised pin level
	assign a_read = a_level & ~port_a_analog_select_r;
	assign b_read = b_level & ~port_b_analog_select_r & `GPP_B_IMPL_MASK;

	// Shared clock function steered by the selection bit
	always_comb begin
		a_own_en = 8'h00;
		a_own_out = a_latch_r;
		b_own_en = periph_b_en_i & `GPP_B_IMPL_MASK;
		b_own_out = (periph_b_en_i & periph_b_out_i) | (~periph_b_en_i & b_latch_r);
		if (sync_clock_en_i) begin
			if (pin_function_steering_r[`GPP_STEER_CLK_BIT]) begin
				b_own_en[5] = 1'b1;
				b_own_out[5] = sync_clock_out_i;
			end else begin
				a_own_en[1] = 1'b1;
				a_own_out[1] = sync_clock_out_i;
			end
		end
	end

	// Effective pull-ups from the current register bits
	always_comb begin
		a_pu_nxt = {8{global_pu_on}} & a_dir_eff & port_a_pullup_enable_r & ~port_a_analog_select_r
			& ~a_own_en & `GPP_A_PU_MASK;
		if (external_reset_pin_mode_i) begin
			a_pu_nxt[`GPP_INPUT_ONLY_BIT] = 1'b1;
		end
		b_pu_nxt = {8{global_pu_on}} & port_b_direction_r & port_b_pullup_enable_r & ~port_b_analog_select_r
			& ~b_own_en & `GPP_B_IMPL_MASK;
	end

	always_comb begin
		unique case (avs_address_i)
			`GPP_OFS_A_DATA: rdata_nxt = a_read;
			`GPP_OFS_A_DIR: rdata_nxt = a_dir_eff;
			`GPP_OFS_A_PULLUP: rdata_nxt = port_a_pullup_enable_r & `GPP_A_PU_MASK;
			`GPP_OFS_A_ANALOG: rdata_nxt = port_a_analog_select_r & `GPP_A_AN_MASK;
			`GPP_OFS_B_DATA: rdata_nxt = b_read;
			`GPP_OFS_B_DIR: rdata_nxt = port_b_direction_r;
			`GPP_OFS_B_PULLUP: rdata_nxt = port_b_pullup_enable_r;
			`GPP_OFS_B_ANALOG: rdata_nxt = port_b_analog_select_r;
			`GPP_OFS_STEER: rdata_nxt = pin_function_steering_r;
			`GPP_OFS_OPTION: rdata_nxt = option_control_r;
			default: rdata_nxt = 8'h00;
		endcase
	end

	// One wait cycle per access, then answer
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r <= gpp_pkg::GPP_IDLE;
			avs_waitrequest_o <= 1'b1;
			avs_readdata_o <= 32'h0000_0000;
		end else begin
			unique case (state_r)
				gpp_pkg::GPP_IDLE: begin
					if (avs_read_i || avs_write_i) begin
						state_r <= gpp_pkg::GPP_ANSWER;
						avs_waitrequest_o <= 1'b0;
						avs_readdata_o <= {24'h00_0000, rdata_nxt};
					end
				end
				gpp_pkg::GPP_ANSWER: begin
					state_r <= gpp_pkg::GPP_IDLE;
					avs_waitrequest_o <= 1'b1;
				end
				default: begin
					state_r <= gpp_pkg::GPP_IDLE;
					avs_waitrequest_o <= 1'b1;
				end
			endcase
		end
	end

	// Direction registers
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			port_a_direction_r <= `GPP_RST_DIR;
			port_b_direction_r <= `GPP_RST_DIR;
		end else if (wr_go) begin
			if (avs_address_i == `GPP_OFS_A_DIR) begin
				port_a_direction_r <= wbyte | (8'h01 << `GPP_INPUT_ONLY_BIT);
			end
			if (avs_address_i == `GPP_OFS_B_DIR) begin
				port_b_direction_r <= wbyte | ~`GPP_B_IMPL_MASK;
			end
		end
	end

	// Pull-up and analog select registers
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			port_a_pullup_enable_r <= `GPP_RST_A_PULLUP;
			port_a_analog_select_r <= `GPP_RST_A_ANALOG;
			port_b_pullup_enable_r <= `GPP_RST_B_PULLUP;
			port_b_analog_select_r <= `GPP_RST_B_ANALOG;
		end else if (wr_go) begin
			if (avs_address_i == `GPP_OFS_A_PULLUP) begin
				port_a_pullup_enable_r <= wbyte & `GPP_A_PU_MASK;
			end
			if (avs_address_i == `GPP_OFS_A_ANALOG) begin
				port_a_analog_select_r <= wbyte & `GPP_A_AN_MASK;
			end
			if (avs_address_i == `GPP_OFS_B_PULLUP) begin
				port_b_pullup_enable_r <= wbyte & `GPP_B_IMPL_MASK;
			end
			if (avs_address_i == `GPP_OFS_B_ANALOG) begin
				port_b_analog_select_r <= wbyte & `GPP_B_AN_MASK;
			end
		end
	end

	// Steering and option registers
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_function_steering_r <= `GPP_RST_STEER;
			option_control_r <= `GPP_RST_OPTION;
		end else if (wr_go) begin
			if (avs_address_i == `GPP_OFS_STEER) begin
				pin_function_steering_r <= wbyte & 8'h01;
			end
			if (avs_address_i == `GPP_OFS_OPTION) begin
				option_control_r <= wbyte;
			end
		end
	end

	// Data latches: the bus write byte is stored, port B bit 3 masked off
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			a_latch_r <= `GPP_RST_LATCH;
			b_latch_r <= `GPP_RST_LATCH;
		end else if (wr_go) begin
			if (avs_address_i == `GPP_OFS_A_DATA) begin
				a_latch_r <= wbyte;
			end
			if (avs_address_i == `GPP_OFS_B_DATA) begin
				b_latch_r <= wbyte & `GPP_B_IMPL_MASK;
			end
		end
	end

	// Pin drivers and pull-ups, registered
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			port_a_pin_o <= 8'h00;
			port_a_pin_oe_o <= 8'h00;
			port_a_pullup_o <= 8'h00;
			port_a_digital_in_en_o <= 8'h00;
			port_b_pin_o <= 8'h00;
			port_b_pin_oe_o <= 8'h00;
			port_b_pullup_o <= 8'h00;
			port_b_digital_in_en_o <= 8'h00;
			sync_clock_pin_choice_o <= 1'b0;
		end else begin
			port_a_pin_o <= a_own_out;
			port_a_pin_oe_o <= ~a_dir_eff;
			port_a_pullup_o <= a_pu_nxt;
			port_a_digital_in_en_o <= ~port_a_analog_select_r;
			port_b_pin_o <= b_own_out & `GPP_B_IMPL_MASK;
			port_b_pin_oe_o <= ~port_b_direction_r & `GPP_B_IMPL_MASK;
			port_b_pullup_o <= b_pu_nxt;
			port_b_digital_in_en_o <= ~port_b_analog_select_r & `GPP_B_IMPL_MASK;
			sync_clock_pin_choice_o <= pin_function_steering_r[`GPP_STEER_CLK_BIT];
		end
	end
endmodule

// ===== tb/gpp_sva.sv
module gpp_sva (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic external_reset_pin_mode_i,
	input wire logic [7:0] port_a_pin_oe_o,
	input wire logic [7:0] port_a_pullup_o,
	input wire logic [7:0] port_a_digital_in_en_o,
	input wire logic [7:0] port_b_pin_oe_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i);
	sequence bus_take;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence one_answer;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	bus_answer_a: assert property (bus_take |=> one_answer)
		else $error("bus answer not a single cycle after take");
	read_upper_a: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h000000)
		else $error("read data upper lanes not zero");
	input_only_a: assert property (!port_a_pin_oe_o[5])
		else $error("input-only pin driven");
	b_gap_a: assert property (!port_b_pin_oe_o[3])
		else $error("missing port b pin driven");
	pu_unimpl_a: assert property (port_a_pullup_o[7:6] == 2'h0 && !port_a_pullup_o[4])
		else $error("pull-up on pin without one");
	pu_output_a: assert property ((port_a_pin_oe_o & port_a_pullup_o) == 8'h00)
		else $error("pull-up on driven pin");
	pu_analog_a: assert property ((port_a_pullup_o[3:0] & ~port_a_digital_in_en_o[3:0]) == 4'h0)
		else $error("pull-up on analog pin");
	din_fixed_a: assert property ($past(arst_n_i) |-> port_a_digital_in_en_o[7:4] == 4'hf)
		else $error("digital input off on non-analog pin");
	rst_pin_a: assert property ($rose(external_reset_pin_mode_i) |-> ##[1:3] port_a_pullup_o[5])
		else $error("reset pin pull-up missing");
endmodule

bind gpp_port gpp_sva u_sva (.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.external_reset_pin_mode_i(external_reset_pin_mode_i), .port_a_pin_oe_o(port_a_pin_oe_o),
	.port_a_pullup_o(port_a_pullup_o), .port_a_digital_in_en_o(port_a_digital_in_en_o),
	.port_b_pin_oe_o(port_b_pin_oe_o));

// ===== tb/gpp_board.sv
module gpp_board (
	input wire logic [7:0] oe_i,
	input wire logic [7:0] out_i,
	input wire logic [7:0] pu_i,
	input wire logic [7:0] ext_i,
	output logic [7:0] pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Driver wins, else pull-up ORed with outside source
	assign pin_o = (oe_i & out_i) | (~oe_i & (pu_i | ext_i));
endmodule

// ===== tb/tb.sv
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; $display("Error %0t got %h exp %h", $time, a, e); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0, arst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0, ext_mode = 1'b0, sync_choice;
	logic sclk_en = 1'b0, sclk_out = 1'b0;
	logic [5:0] avs_address_i = 6'h00;
	logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
	logic [3:0] avs_byteenable_i = 4'h1;
	logic avs_waitrequest_o;
	logic [7:0] a_pin, a_out, a_oe, a_pu, a_din, b_pin, b_out, b_oe, b_pu, b_din, q_x;
	logic [7:0] periph_en = 8'h00, periph_out = 8'h00;
	logic [5:0] ra[6] = '{6'h04, 6'h08, 6'h0c, 6'h14, 6'h1c, 6'h20};
	logic [7:0] rv[6] = '{8'hff, 8'h2f, 8'h0f, 8'hff, 8'h36, 8'h00};
	int errors = 0;
	int total_checks = 0;
	initial forever #50 clk_i = ~clk_i;
	gpp_port uut (.clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.external_reset_pin_mode_i(ext_mode), .port_a_pin_i(a_pin), .port_a_pin_o(a_out), .port_a_pin_oe_o(a_oe),
		.port_a_pullup_o(a_pu), .port_a_digital_in_en_o(a_din), .port_b_pin_i(b_pin), .port_b_pin_o(b_out),
		.port_b_pin_oe_o(b_oe), .port_b_pullup_o(b_pu), .port_b_digital_in_en_o(b_din), .periph_b_en_i(periph_en),
		.periph_b_out_i(periph_out), .sync_clock_en_i(sclk_en), .sync_clock_out_i(sclk_out),
		.sync_clock_pin_choice_o(sync_choice));
	gpp_board brd_a (.oe_i(a_oe), .out_i(a_out), .pu_i(a_pu), .ext_i(8'h00), .pin_o(a_pin));
	gpp_board brd_b (.oe_i(b_oe), .out_i(b_out), .pu_i(b_pu), .ext_i(8'h00), .pin_o(b_pin));
	task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d, input logic [3:0] be,
		output logic [7:0] q);
		@(posedge clk_i);
		avs_address_i <= a;
		avs_read_i <= !w;
		avs_write_i <= w;
		avs_writedata_i <= {24'h000000, d};
		avs_byteenable_i <= be;
		do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o[7:0];
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(1'b1, a, d, 4'h1, q);
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		logic [7:0] q;
		acc(1'b0, a, 8'h00, 4'h1, q);
		`CHK(q, e)
	endtask
	task settle;
		repeat (6) @(posedge clk_i);
	endtask
	task print_verdict;
		if (errors == 0 && total_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_i);
		errors++;
		print_verdict();
	end
	initial begin
		repeat (5) @(posedge clk_i);
		arst_n_i <= 1'b1;
		settle();
		`CHK(a_pu, 8'h00)
		for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
		wr(6'h24, 8'h7f);
		settle();
		`CHK(a_pu, 8'h20)
		`CHK(a_din[3:0], 4'h0)
		acc(1'b1, 6'h0c, 8'h00, 4'h0, q_x);
		rd(6'h0c, 8'h0f);
		wr(6'h0c, 8'hff);
		rd(6'h0c, 8'h0f);
		wr(6'h0c, 8'h00);
		settle();
		`CHK(a_pu, 8'h2f)
		wr(6'h04, 8'h00);
		rd(6'h04, 8'h20);
		settle();
		`CHK(a_oe, 8'hdf)
		`CHK(a_pu, 8'h20)
		wr(6'h08, 8'hff);
		rd(6'h08, 8'h2f);
		wr(6'h08, 8'h00);
		ext_mode <= 1'b1;
		settle();
		`CHK(a_pu, 8'h20)
		wr(6'h0c, 8'h0f);
		wr(6'h00, 8'ha5);
		settle();
		`CHK(a_out & a_oe, 8'h85)
		rd(6'h00, 8'ha0);
		wr(6'h1c, 8'h00);
		wr(6'h14, 8'h00);
		wr(6'h10, 8'h3c);
		periph_en <= 8'h01;
		periph_out <= 8'h01;
		settle();
		`CHK(b_oe, 8'hf7)
		rd(6'h10, 8'h35);
		wr(6'h1c, 8'h36);
		settle();
		`CHK(b_oe, 8'hf7)
		rd(6'h10, 8'h01);
		wr(6'h10, 8'hc0);
		settle();
		rd(6'h10, 8'hc1);
		wr(6'h20, 8'h01);
		rd(6'h20, 8'h01);
		`CHK(sync_choice, 1'b1)
		sclk_en <= 1'b1;
		sclk_out <= 1'b1;
		wr(6'h18, 8'hff);
		wr(6'h14, 8'hdf);
		settle();
		`CHK(b_out[5], 1'b1)
		`CHK(b_pu, 8'hc0)
		`CHK(b_din, 8'hc1)
		`CHK(a_out[1], 1'b0)
		wr(6'h20, 8'h00);
		settle();
		`CHK(a_out[1], 1'b1)
		`CHK(b_out[5], 1'b0)
		rd(6'h3c, 8'h00);
		print_verdict();
	end
endmodule
